// *** rtl/sct_ctl_end.sv ***
/*
 sct_ctl_end: controller end. initialises the memory, then serves one
 single-word read or write at a time with the precharge-after-access flag,
 and parks the memory in self refresh on request.
 assumes the memory end on the same clock behind sct_link_if.
*/
`timescale 1ns/1ns
module sct_ctl_end (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    sct_link_if.ctl link, // pins toward the memory
    input wire logic req_valid, // access request
    input wire logic req_write, // 1 write, 0 read
    input wire logic [sct_pkg::BA_W-1:0] req_bank, // bank
    input wire logic [sct_pkg::ADDR_W-1:0] req_row, // row
    input wire logic [sct_pkg::COL_W-1:0] req_col, // column
    input wire logic [sct_pkg::DQ_W-1:0] req_wdata, // write word
    input wire logic [sct_pkg::MASK_W-1:0] req_mask, // byte mask, high blocks
    input wire logic sleep, // level: hold memory in self refresh
    output logic req_ready, // request taken when valid and ready with sleep low
    output logic init_done, // initialisation finished
    output logic rd_valid, // one-cycle read data strobe
    output logic [sct_pkg::DQ_W-1:0] rd_data // read word
);
    import sct_pkg::*;

    typedef struct packed {
        sct_ctl_state_t st;
        logic [3:0] cnt;
        logic [3:0] act_gap;
        logic [1:0] refs;
        logic ready;
        logic done;
        logic wr;
        logic [BA_W-1:0] bank;
        logic [ADDR_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DQ_W-1:0] wdata;
        logic [MASK_W-1:0] mask;
        logic [2:0] rd_sh;
        logic rd_v;
        logic [DQ_W-1:0] rd_d;
        logic cke;
        logic cs_n;
        sct_cmd_t cmd;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] dqm;
        logic [DQ_W-1:0] dq_out;
        logic dq_oe_n;
    } sct_ctl_st_t;

    sct_ctl_st_t s;
    sct_ctl_st_t next_s;

    always_comb begin
        next_s = s;
        next_s.cs_n = 1'b1;
        next_s.cmd = SCT_CMD_NOP;
        next_s.dq_oe_n = 1'b1;
        next_s.dqm = '0;
        next_s.rd_v = 1'b0;
        next_s.rd_sh = {s.rd_sh[1:0], 1'b0};
        next_s.ready = 1'b0;
        if (s.act_gap != 4'h0) begin
            next_s.act_gap = s.act_gap - 4'h1;
        end
        // word leaves the memory flop one edge after it sees the read
        if (s.rd_sh[2]) begin
            next_s.rd_v = 1'b1;
            next_s.rd_d = link.dq;
        end
        if (s.cnt != 4'h0) begin
            next_s.cnt = s.cnt - 4'h1;
        end else begin
            case (s.st)
                SCT_ST_PRE: begin
                    next_s.cke = 1'b1;
                    if (s.cke) begin
                        next_s.cs_n = 1'b0;
                        next_s.cmd = SCT_CMD_PRECHARGE;
                        next_s.addr[PRE_FLAG_BIT] = 1'b1;
                        next_s.cnt = 4'(ROW_PRECHARGE_CYC - 1);
                        next_s.st = SCT_ST_REF;
                    end
                end
                SCT_ST_REF: begin
                    next_s.cs_n = 1'b0;
                    next_s.cmd = SCT_CMD_REFRESH;
                    next_s.cnt = 4'(ROW_CYCLE_CYC - 1);
                    next_s.refs = s.refs + 2'h1;
                    if (s.refs == 2'(INIT_REFRESHES - 1)) begin
                        next_s.st = SCT_ST_MODE;
                    end
                end
                SCT_ST_MODE: begin
                    next_s.cs_n = 1'b0;
                    next_s.cmd = SCT_CMD_MODE;
                    {next_s.ba, next_s.addr} = CTL_MODE_WORD;
                    next_s.cnt = 4'(MODE_LOAD_WAIT - 1);
                    next_s.done = 1'b1;
                    next_s.st = SCT_ST_IDLE;
                end
                SCT_ST_IDLE: begin
                    if (sleep) begin
                        next_s.cs_n = 1'b0;
                        next_s.cmd = SCT_CMD_REFRESH;
                        next_s.cke = 1'b0;
                        next_s.st = SCT_ST_SREF;
                    end else if (s.ready && req_valid) begin
                        next_s.wr = req_write;
                        next_s.bank = req_bank;
                        next_s.row = req_row;
                        next_s.col = req_col;
                        next_s.wdata = req_wdata;
                        next_s.mask = req_mask;
                        next_s.st = SCT_ST_ACT;
                    end else begin
                        next_s.ready = (s.act_gap == 4'h0);
                    end
                end
                SCT_ST_ACT: begin
                    next_s.cs_n = 1'b0;
                    next_s.cmd = SCT_CMD_ACTIVATE;
                    next_s.ba = s.bank;
                    next_s.addr = s.row;
                    next_s.act_gap = 4'(ACT_GAP_CYC);
                    next_s.cnt = 4'(ROW_TO_COLUMN_CYC - 1);
                    next_s.st = SCT_ST_COL;
                end
                SCT_ST_COL: begin
                    next_s.cs_n = 1'b0;
                    next_s.cmd = s.wr ? SCT_CMD_WRITE : SCT_CMD_READ;
                    next_s.ba = s.bank;
                    next_s.addr = '0;
                    next_s.addr[COL_LSB +: COL_W] = s.col;
                    next_s.addr[PRE_FLAG_BIT] = 1'b1;
                    next_s.dqm = s.mask;
                    if (s.wr) begin
                        next_s.dq_out = s.wdata;
                        next_s.dq_oe_n = 1'b0;
                        // activate gap covers precharge and column gaps too
                        next_s.cnt = 4'(WRITE_END_TO_ACTIVATE_GAP);
                    end else begin
                        next_s.rd_sh = 3'b001;
                        next_s.cnt = 4'(READ_LATENCY + ROW_PRECHARGE_CYC);
                    end
                    next_s.st = SCT_ST_WAIT;
                end
                SCT_ST_WAIT: begin
                    next_s.st = SCT_ST_IDLE;
                end
                SCT_ST_SREF: begin
                    if (!sleep) begin
                        next_s.cke = 1'b1;
                        next_s.cnt = 4'(ROW_CYCLE_CYC);
                        next_s.st = SCT_ST_WAIT;
                    end
                end
                default: begin
                    next_s.st = SCT_ST_PRE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            s.st <= SCT_ST_PRE;
            s.cs_n <= 1'b1;
            s.cmd <= SCT_CMD_NOP;
            s.dq_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.cke = s.cke;
    assign link.cs_n = s.cs_n;
    assign {link.ras_n, link.cas_n, link.we_n} = s.cmd;
    assign link.ba = s.ba;
    assign link.addr = s.addr;
    assign link.dqm = s.dqm;
    assign link.ctl_dq_out = s.dq_out;
    assign link.ctl_dq_oe_n = s.dq_oe_n;
    assign req_ready = s.ready;
    assign init_done = s.done;
    assign rd_valid = s.rd_v;
    assign rd_data = s.rd_d;
endmodule // sct_ctl_end

// *** rtl/sct_pkg.sv ***
/*
 sct_pkg: command codes, pin widths, timing counts and state encodings
 shared by both ends of the synchronous DRAM command link.
 assumes a single 25 MHz clock shared by controller and memory.
*/
package sct_pkg;
    localparam int CLK_NS = 40;
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int DQ_W = 16;
    localparam int MASK_W = 2;
    localparam int MODE_W = ADDR_W + BA_W;
    localparam int PRE_FLAG_BIT = 10;
    localparam int COL_LSB = 0;
    localparam int COL_W = 10;
    localparam int BL_LSB = 0;
    localparam int BL_W = 3;
    localparam int LEFT_W = 11;
    // ns minimums, slower grade
    localparam int ACTIVATE_TO_ACTIVATE_GAP_NS = 20;
    localparam int ROW_PRECHARGE_TIME_NS = 20;
    localparam int ROW_TO_COLUMN_NS = 20;
    localparam int ROW_CYCLE_NS = 70;
    localparam int ACT_GAP_CYC = (ACTIVATE_TO_ACTIVATE_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_TO_COLUMN_CYC = (ROW_TO_COLUMN_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    // counts already in clocks
    localparam int WRITE_END_TO_ACTIVATE_GAP = 2;
    localparam int WRITE_END_TO_COLUMN_GAP = 1;
    localparam int WRITE_END_TO_PRECHARGE_GAP = 2;
    localparam int COLUMN_TO_COLUMN_GAP = 1;
    localparam int MODE_LOAD_WAIT = 2;
    localparam int READ_LATENCY = 2;
    localparam int INIT_REFRESHES = 2;
    // burst length 1, read latency 2
    localparam logic [MODE_W-1:0] CTL_MODE_WORD = 15'h0020;
    localparam logic [MODE_W-1:0] MODE_RST = 15'h0000;

    // {row strobe, column strobe, write enable}
    typedef enum logic [2:0] {
        SCT_CMD_MODE = 3'h0,
        SCT_CMD_REFRESH = 3'h1,
        SCT_CMD_PRECHARGE = 3'h2,
        SCT_CMD_ACTIVATE = 3'h3,
        SCT_CMD_WRITE = 3'h4,
        SCT_CMD_READ = 3'h5,
        SCT_CMD_BURST_STOP = 3'h6,
        SCT_CMD_NOP = 3'h7
    } sct_cmd_t;

    typedef enum logic [1:0] {
        SCT_PWR_RUN = 2'h0,
        SCT_PWR_SUSPEND = 2'h1,
        SCT_PWR_PDOWN = 2'h3,
        SCT_PWR_SELF = 2'h2
    } sct_pwr_t;

    typedef enum logic [3:0] {
        SCT_ST_PRE = 4'h0,
        SCT_ST_REF = 4'h1,
        SCT_ST_MODE = 4'h3,
        SCT_ST_IDLE = 4'h2,
        SCT_ST_ACT = 4'h6,
        SCT_ST_COL = 4'h7,
        SCT_ST_WAIT = 4'h5,
        SCT_ST_SREF = 4'h4
    } sct_ctl_state_t;
endpackage

// *** rtl/sct_link_if.sv ***
/*
 sct_link_if: the command, address, mask and data pins between the
 controller end and the memory end. assumes both ends share one clock;
 the data wire is resolved here from the two enables, no high impedance.
*/
`timescale 1ns/1ns
interface sct_link_if;
    import sct_pkg::*;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [MASK_W-1:0] dqm;
    logic [DQ_W-1:0] ctl_dq_out;
    logic ctl_dq_oe_n;
    logic [DQ_W-1:0] mem_dq_out;
    logic [MASK_W-1:0] mem_dq_oe_n;
    logic [DQ_W-1:0] dq;

    // a lane nobody drives reads as zero
    always_comb begin
        for (int i = 0; i < MASK_W; i++) begin
            if (!mem_dq_oe_n[i]) begin
                dq[i*8 +: 8] = mem_dq_out[i*8 +: 8];
            end else if (!ctl_dq_oe_n) begin
                dq[i*8 +: 8] = ctl_dq_out[i*8 +: 8];
            end else begin
                dq[i*8 +: 8] = 8'h00;
            end
        end
    end

    modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
        output mem_dq_out, mem_dq_oe_n);
    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq_out,
        ctl_dq_oe_n, input dq);
endinterface

// *** rtl/sct_mem_end.sv ***
/*
 sct_mem_end: memory end. decodes commands on each rising edge, keeps
 bank and mode state, runs read and write bursts with read latency 2 and
 byte masks, and follows clock enable into suspend, power-down or self
 refresh. storage is a small array indexed by bank, low row and low
 column bits. assumes the controller end on the same clock.
*/
// Summary of operation
// - activates to different banks spaced by minimum gap
// - nanosecond minimums rounded up to whole clocks
// - activate waits two clocks after last write word
// - new column waits one clock after write
// - new read or write accepted every clock
// - cut-short read still yields one more word
// - strobes with select low choose the command
// - no read or write during auto-precharge burst
// - same bank reactivates after precharge time elapses
// - precharge with flag high closes all banks
// - bank-select inputs pick banks A to D
// - mode load only with all banks idle
// - mode load followed by two idle clocks; the controller end leaves only one when sleep is already high
// - refresh only with all banks precharged
// - refresh leaves all rows precharged internally
// - burst stop ends any burst length
// - write mask blocks same-cycle data
// - read mask floats data two clocks later
// - mode load takes address and bank inputs
// - clock enable falling enters, rising exits low power
`timescale 1ns/1ns
module sct_mem_end #(
    parameter int ROW_W = 2, // stored row bits per bank
    parameter int STORE_COL_W = 4 // stored column bits
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    sct_link_if.mem link, // pins from the controller
    output logic [sct_pkg::MODE_W-1:0] mode_word, // last mode operand
    output logic [3:0] bank_open, // one bit per bank, row open
    output sct_pkg::sct_pwr_t power_state, // run, suspend, power-down, self
    output logic refresh_pulse // one cycle per auto refresh
);
    import sct_pkg::*;

    localparam int IDX_W = BA_W + ROW_W + STORE_COL_W;
    localparam int DEPTH = 1 << IDX_W;

    typedef struct packed {
        logic cke_q;
        sct_pwr_t pwr;
        logic [MODE_W-1:0] mode;
        logic [3:0] open;
        logic [3:0][ROW_W-1:0] row;
        logic bact;
        logic bwr;
        logic bap;
        logic [BA_W-1:0] bbank;
        logic [STORE_COL_W-1:0] col;
        logic [LEFT_W-1:0] left;
        logic p_v;
        logic [MASK_W-1:0] p_m;
        logic [DQ_W-1:0] p_d;
        logic [MASK_W-1:0] o_oe_n;
        logic [DQ_W-1:0] o_d;
        logic refreshed;
        logic [DEPTH-1:0][DQ_W-1:0] mem;
    } sct_mem_st_t;

    sct_mem_st_t s;
    sct_mem_st_t next_s;
    sct_cmd_t cmd;
    logic cmd_on;
    logic pre_hit;
    logic [IDX_W-1:0] idx;

    // full page stops after 1024 words, or earlier on burst stop, precharge of its bank or all banks, or a new column command
    function automatic logic [LEFT_W-1:0] sct_burst_words(input logic [BL_W-1:0] code);
        case (code)
            3'h0: return 11'h001;
            3'h1: return 11'h002;
            3'h2: return 11'h004;
            3'h3: return 11'h008;
            3'h7: return 11'h400;
            default: return 11'h001;
        endcase
    endfunction

    always_comb begin
        next_s = s;
        idx = '0;
        pre_hit = 1'b0;
        next_s.cke_q = link.cke;
        next_s.refreshed = 1'b0;
        cmd = sct_cmd_t'({link.ras_n, link.cas_n, link.we_n});
        cmd_on = s.cke_q && !link.cs_n;

        // previous-cycle enable against current one
        if (s.cke_q && !link.cke) begin
            if (cmd_on && cmd == SCT_CMD_REFRESH) begin
                next_s.pwr = SCT_PWR_SELF;
            end else if (s.open == 4'h0 && !s.bact) begin
                next_s.pwr = SCT_PWR_PDOWN;
            end else begin
                next_s.pwr = SCT_PWR_SUSPEND;
            end
        end else if (!s.cke_q && link.cke) begin
            next_s.pwr = SCT_PWR_RUN;
        end

        // with enable low last cycle banks, bursts and outputs freeze; only power state, enable sample and refresh pulse update
        if (s.cke_q) begin
            next_s.o_d = s.p_d;
            next_s.o_oe_n = s.p_v ? s.p_m : {MASK_W{1'b1}};
            next_s.p_v = 1'b0;
            next_s.p_m = link.dqm;
            if (cmd_on) begin
                case (cmd)
                    SCT_CMD_MODE: begin
                        next_s.mode = {link.ba, link.addr};
                    end
                    SCT_CMD_REFRESH: begin
                        if (link.cke) begin
                            next_s.open = 4'h0;
                            next_s.refreshed = 1'b1;
                        end
                    end
                    SCT_CMD_ACTIVATE: begin
                        next_s.open[link.ba] = 1'b1;
                        next_s.row[link.ba] = link.addr[ROW_W-1:0];
                    end
                    SCT_CMD_READ, SCT_CMD_WRITE: begin
                        // a new column command cuts any running burst
                        next_s.bact = 1'b1;
                        next_s.bwr = (cmd == SCT_CMD_WRITE);
                        next_s.bap = link.addr[PRE_FLAG_BIT];
                        next_s.bbank = link.ba;
                        next_s.col = link.addr[COL_LSB +: STORE_COL_W];
                        next_s.left = sct_burst_words(s.mode[BL_LSB +: BL_W]);
                    end
                    SCT_CMD_BURST_STOP: begin
                        next_s.bact = 1'b0;
                    end
                    SCT_CMD_PRECHARGE: begin
                        if (link.addr[PRE_FLAG_BIT]) begin
                            next_s.open = 4'h0;
                            pre_hit = 1'b1;
                        end else begin
                            next_s.open[link.ba] = 1'b0;
                            pre_hit = (link.ba == s.bbank);
                        end
                        if (pre_hit) begin
                            next_s.bact = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end

            // word already in the pipe still leaves after a cut
            if (next_s.bact) begin
                idx = {next_s.bbank, next_s.row[next_s.bbank], next_s.col};
                if (next_s.bwr) begin
                    for (int i = 0; i < MASK_W; i++) begin
                        if (!link.dqm[i]) begin
                            next_s.mem[idx][i*8 +: 8] = link.dq[i*8 +: 8];
                        end
                    end
                end else begin
                    next_s.p_v = 1'b1;
                    next_s.p_d = s.mem[idx];
                end
                next_s.col = next_s.col + STORE_COL_W'(1);
                next_s.left = next_s.left - LEFT_W'(1);
                if (next_s.left == '0) begin
                    next_s.bact = 1'b0;
                    if (next_s.bap) begin
                        next_s.open[next_s.bbank] = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            s.mode <= MODE_RST;
            s.pwr <= SCT_PWR_RUN;
            s.o_oe_n <= {MASK_W{1'b1}};
        end else begin
            s <= next_s;
        end
    end

    assign link.mem_dq_out = s.o_d;
    assign link.mem_dq_oe_n = s.o_oe_n;
    assign mode_word = s.mode;
    assign bank_open = s.open;
    assign power_state = s.pwr;
    assign refresh_pulse = s.refreshed;
endmodule // sct_mem_end

// *** bench/sct_link_assertions.sv ***
/*
 sct_link_assertions: timing checks on the pins between the two ends.
 assumes one clock for both ends and the controller's burst length of one.
*/
`timescale 1ns/1ns
module sct_link_assertions (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic cke, // clock enable
    input wire logic cs_n, // chip select
    input wire logic ras_n, // row strobe
    input wire logic cas_n, // column strobe
    input wire logic we_n, // write enable
    input wire logic [sct_pkg::BA_W-1:0] ba, // bank select
    input wire logic [sct_pkg::ADDR_W-1:0] addr, // address
    input wire logic [sct_pkg::MASK_W-1:0] dqm, // byte mask
    input wire logic ctl_dq_oe_n, // controller drives data
    input wire logic [sct_pkg::MASK_W-1:0] mem_dq_oe_n // memory drives lanes
);
    import sct_pkg::*;
    logic [2:0] cmd;
    logic cke_q;
    logic issued;
    logic col_now;
    logic rd_now;
    assign cmd = {ras_n, cas_n, we_n};
    // a command counts only if clock enable was high one edge before
    assign issued = !cs_n && cke_q && cmd != SCT_CMD_NOP;
    assign rd_now = issued && cmd == SCT_CMD_READ;
    assign col_now = rd_now || (issued && cmd == SCT_CMD_WRITE);
    always_ff @(posedge clk) begin
        cke_q <= reset ? 1'b0 : cke;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence mode_s; issued && cmd == SCT_CMD_MODE; endsequence
    sequence ref_s; !cs_n && cke_q && cmd == SCT_CMD_REFRESH; endsequence
    sequence act_s; issued && cmd == SCT_CMD_ACTIVATE; endsequence
    sequence rd_s; rd_now; endsequence
    mode_gap_a: assert property (mode_s |=> !issued [*2])
        else $error("command too soon after mode load");
    mode_op_a: assert property (mode_s |-> {ba, addr} == CTL_MODE_WORD)
        else $error("mode operand wrong");
    ref_gap_a: assert property (ref_s |=> !issued)
        else $error("command right after refresh");
    act_col_a: assert property (act_s |=> col_now && ba == $past(ba))
        else $error("activate not followed by column command to its bank");
    col_flag_a: assert property (col_now |-> addr[PRE_FLAG_BIT] ##1 !col_now)
        else $error("column command during auto precharge burst");
    wr_drive_a: assert property (issued && cmd == SCT_CMD_WRITE |-> !ctl_dq_oe_n)
        else $error("write data not driven with command");
    rd_lat_a: assert property (rd_s |-> ##2 mem_dq_oe_n == $past(dqm, 2))
        else $error("read lanes do not follow mask two clocks later");
    dq_idle_a: assert property (!$past(rd_now, 2) |-> mem_dq_oe_n == 2'h3)
        else $error("memory drives data outside read slot");
    cke_exit_a: assert property ($rose(cke) |-> cs_n || cmd == SCT_CMD_NOP)
        else $error("command issued with clock enable exit");
endmodule // sct_link_assertions

// *** bench/tb.sv ***
/*
 tb: both ends joined by sct_link_if; random and corner accesses checked
 against a word model. assumes the controller end and memory end in rtl/.
*/
`timescale 1ns/1ns
module tb;
    import sct_pkg::*;
    // 83 accesses of under 40 clocks plus init and sleep
    localparam int WATCHDOG_CYC = 5000;
    logic clk, reset, req_valid, req_write, sleep, req_ready, init_done, rd_valid;
    logic refresh_pulse;
    logic [1:0] req_bank, req_mask;
    logic [12:0] req_row;
    logic [9:0] req_col;
    logic [15:0] req_wdata, rd_data, refs;
    logic [14:0] mode_word;
    logic [3:0] bank_open;
    sct_pwr_t power_state;
    logic [15:0] store [256];
    logic [31:0] seed, r, q;
    int fails = 0;
    int checks = 0;
    int n;
    sct_link_if link();
    sct_ctl_end i_sct_ctl_end (.clk(clk), .reset(reset), .link(link), .req_valid(req_valid),
        .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
        .req_wdata(req_wdata), .req_mask(req_mask), .sleep(sleep), .req_ready(req_ready),
        .init_done(init_done), .rd_valid(rd_valid), .rd_data(rd_data));
    sct_mem_end #(.ROW_W(2), .STORE_COL_W(4)) i_sct_mem_end (.clk(clk), .reset(reset),
        .link(link), .mode_word(mode_word), .bank_open(bank_open),
        .power_state(power_state), .refresh_pulse(refresh_pulse));
    sct_link_assertions i_sct_link_assertions (.clk(clk), .reset(reset), .cke(link.cke),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .ba(link.ba), .addr(link.addr), .dqm(link.dqm), .ctl_dq_oe_n(link.ctl_dq_oe_n),
        .mem_dq_oe_n(link.mem_dq_oe_n));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // masked lanes float and the link resolves them to zero
    function automatic logic [15:0] rd_exp(logic [15:0] v, logic [1:0] m);
        return {m[1] ? 8'h00 : v[15:8], m[0] ? 8'h00 : v[7:0]};
    endfunction

    function automatic logic [15:0] wr_merge(logic [15:0] o, logic [15:0] d, logic [1:0] m);
        return {m[1] ? o[15:8] : d[15:8], m[0] ? o[7:0] : d[7:0]};
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report;
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_ready;
        n = 0;
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("req_ready", 16'h0001, {15'h0000, req_ready});
    endtask

    task automatic access(input logic w, input logic [1:0] b, input logic [12:0] rw,
        input logic [9:0] c, input logic [15:0] d, input logic [1:0] m);
        logic [7:0] k;
        k = {b, rw[1:0], c[3:0]};
        req_valid = 1'b1;
        req_write = w;
        req_bank = b;
        req_row = rw;
        req_col = c;
        req_wdata = d;
        req_mask = m;
        wait_ready();
        chk("bank_open", 16'h0000, {12'h000, bank_open});
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        if (w) begin
            store[k] = wr_merge(store[k], d, m);
            // let an edge pass before the next request raises valid
            @(posedge clk);
            #1;
        end else begin
            n = 0;
            while (rd_valid !== 1'b1 && n < 20) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
            chk("rd_data", rd_exp(store[k], m), rd_data);
        end
    endtask

    always @(posedge clk) begin
        if (reset) begin
            refs <= 16'h0000;
        end else if (refresh_pulse === 1'b1) begin
            refs <= refs + 16'h0001;
        end
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (WATCHDOG_CYC) @(posedge clk);
        fails++;
        final_report();
    end

    initial begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_bank = 2'h0;
        req_row = 13'h0000;
        req_col = 10'h000;
        req_wdata = 16'h0000;
        req_mask = 2'h0;
        sleep = 1'b0;
        seed = 32'h54;
        for (int i = 0; i < 256; i++) begin
            store[i] = 16'h0000;
        end
        repeat (16) @(posedge clk);
        #1;
        reset = 1'b0;
        wait_ready();
        chk("init_done", 16'h0001, {15'h0000, init_done});
        chk("refreshes", 16'h0002, refs);
        chk("mode_word", {1'b0, CTL_MODE_WORD}, {1'b0, mode_word});
        // every bank and mask, top row and column, write then read back
        for (int b = 0; b < 4; b++) begin
            for (int m = 0; m < 4; m++) begin
                r = rnd();
                access(1'b1, b[1:0], 13'h1fff, 10'h3ff, r[15:0], m[1:0]);
                access(1'b0, b[1:0], 13'h1fff, 10'h3ff, 16'h0000, m[1:0]);
            end
        end
        repeat (50) begin
            r = rnd();
            q = rnd();
            access(r[0], r[2:1], r[15:3], r[25:16], q[15:0], r[27:26]);
        end
        sleep = 1'b1;
        n = 0;
        while (power_state !== SCT_PWR_SELF && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        repeat (8) @(posedge clk);
        #1;
        chk("self_state", {14'h0000, SCT_PWR_SELF}, {14'h0000, power_state});
        chk("ready_in_self", 16'h0000, {15'h0000, req_ready});
        sleep = 1'b0;
        wait_ready();
        chk("run_state", {14'h0000, SCT_PWR_RUN}, {14'h0000, power_state});
        access(1'b0, 2'h3, 13'h1fff, 10'h3ff, 16'h0000, 2'h0);
        final_report();
    end
endmodule // tb
